// ---- hdl/sfr_front_end_chip.sv ----
// one front_end_chip of the six-axis force readout: link slave, conversion
// sequencer with temperature offset correction and coefficient memory.
// assumes a link master driving link_sclk (mode 0, msb first) and cs_n;
// link_sclk may stop outside frames. analog results arrive on adc_code and
// temp_code, the factory coefficient image on nvm_image, all asynchronous.
`include "sfr_regs.svh"
`default_nettype none

module sfr_front_end_chip
   import sfr_pkg::*;
#(
   parameter int FIRST_CONV_CYCLES = `SFR_FIRST_CONV_US * (`SFR_CORE_CLK_KHZ / 1000),
   parameter int CONV_INTERVAL_CYCLES = `SFR_CONV_INTERVAL_US * (`SFR_CORE_CLK_KHZ / 1000)
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic link_sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic [23:0] adc_code,
   input wire logic [23:0] temp_code,
   input wire logic [143:0] nvm_image,
   output logic conversion_active
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sfr_core_s c_r;
   sfr_core_s c_nxt;
   sfr_link_s l_r;
   sfr_link_s l_nxt;
   sfr_frame_s f_r;
   sfr_frame_s f_nxt;
   sfr_out_s o_r;
   sfr_out_s o_nxt;
   logic frame_rst;
   logic cmd_evt;
   logic [7:0] rx_byte;

   localparam logic [7:0] COEFF_BASE [0:5] = '{
      `SFR_COEFF_ONE_ADDR, `SFR_COEFF_TWO_ADDR, `SFR_COEFF_THREE_ADDR,
      `SFR_COEFF_FOUR_ADDR, `SFR_COEFF_FIVE_ADDR, `SFR_COEFF_SIX_ADDR
   };

   // byte of the coefficient memory; the reserved gap and all other
   // addresses read as zero
   function automatic logic [7:0] nvm_byte(input logic [7:0] addr, input logic [143:0] coeff);
      logic [7:0] val;
      val = `SFR_NVM_UNMAPPED;
      for (int k = 0; k < 6; k++) begin
         for (int b = 0; b < 3; b++) begin
            if (addr == COEFF_BASE[k] + 8'(b)) begin
               val = coeff[k * 24 + (2 - b) * 8 +: 8];
            end
         end
      end
      return val;
   endfunction : nvm_byte

   // ----------------------------------------------------------------
   // core domain: conversion sequencer
   // ----------------------------------------------------------------
   assign cmd_evt = c_r.cmd_s3 != c_r.cmd_s2;

   always_comb begin
      c_nxt = c_r;
      c_nxt.cmd_s1 = l_r.cmd_tog;
      c_nxt.cmd_s2 = c_r.cmd_s1;
      c_nxt.cmd_s3 = c_r.cmd_s2;
      c_nxt.adc_s1 = adc_code;
      c_nxt.adc_s2 = c_r.adc_s1;
      c_nxt.temp_s1 = temp_code;
      c_nxt.temp_s2 = c_r.temp_s1;
      c_nxt.img_s1 = nvm_image;
      c_nxt.img_s2 = c_r.img_s1;

      // the image is static; it is caught once, after the synchroniser
      // has settled, and from then on the link may read it without a synchroniser while conversion is idle
      if (!c_r.coeff_valid) begin
         if (c_r.ld_cnt == `SFR_COEFF_LOAD_WAIT) begin
            c_nxt.coeff = c_r.img_s2;
            c_nxt.coeff_valid = 1'b1;
         end else begin
            c_nxt.ld_cnt = c_r.ld_cnt + 2'h1;
         end
      end

      if (c_r.timer != 21'h000000) begin
         c_nxt.timer = c_r.timer - 21'h000001;
      end

      case (c_r.state)
         SFR_CONV_IDLE: begin
            if (cmd_evt && l_r.cmd_code == `SFR_CMD_ACTIVE) begin
               c_nxt.state = SFR_CONV_FIRST;
               c_nxt.timer = 21'(FIRST_CONV_CYCLES - 1);
               c_nxt.sample = `SFR_SAMPLE_RST;
               c_nxt.pub_tog = ~c_r.pub_tog;
            end
         end
         SFR_CONV_FIRST: begin
            if (c_r.timer == 21'h000000) begin
               // first conversion also measures temperature
               c_nxt.temp_ref = c_r.temp_s2;
               c_nxt.sample = c_r.adc_s2 - c_r.temp_s2;
               c_nxt.pub_tog = ~c_r.pub_tog;
               c_nxt.state = SFR_CONV_RUN;
               c_nxt.timer = 21'(CONV_INTERVAL_CYCLES - 1);
            end
         end
         SFR_CONV_RUN: begin
            if (c_r.timer == 21'h000000) begin
               // wraps on overflow, as the analog path would saturate first
               c_nxt.sample = c_r.adc_s2 - c_r.temp_ref;
               c_nxt.pub_tog = ~c_r.pub_tog;
               c_nxt.timer = 21'(CONV_INTERVAL_CYCLES - 1);
            end
            if (cmd_evt && l_r.cmd_code == `SFR_CMD_TEMP_UPDATE) begin
               c_nxt.temp_ref = c_r.temp_s2;
            end
         end
         default: begin
            c_nxt.state = SFR_CONV_IDLE;
         end
      endcase

      // idle stops conversion but keeps the last sample for reading
      if (cmd_evt && l_r.cmd_code == `SFR_CMD_IDLE) begin
         c_nxt.state = SFR_CONV_IDLE;
         c_nxt.timer = 21'h000000;
      end
      c_nxt.active = c_nxt.state != SFR_CONV_IDLE;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         c_r <= '{state: SFR_CONV_IDLE, temp_ref: `SFR_TEMP_RST, sample: `SFR_SAMPLE_RST, default: '0};
      end else begin
         c_r <= c_nxt;
      end
   end

   // ----------------------------------------------------------------
   // link domain: frame decode and reply
   // ----------------------------------------------------------------
   // a frame ends on cs_n alone, since no clock edge follows it
   assign frame_rst = reset | cs_n;
   assign rx_byte = {f_r.rx, mosi};

   always_comb begin
      l_nxt = l_r;
      f_nxt = f_r;
      l_nxt.idle_s1 = ~c_r.active;
      l_nxt.idle_s2 = l_r.idle_s1;
      l_nxt.cvalid_s1 = c_r.coeff_valid;
      l_nxt.cvalid_s2 = l_r.cvalid_s1;
      l_nxt.pub_s1 = c_r.pub_tog;
      l_nxt.pub_s2 = l_r.pub_s1;
      // the sample word is stable long before its toggle gets here
      if (l_r.pub_s2 != l_r.pub_seen) begin
         l_nxt.shadow = c_r.sample;
         l_nxt.pub_seen = l_r.pub_s2;
      end

      f_nxt.rx = rx_byte[6:0];
      f_nxt.bit_cnt = f_r.bit_cnt + 3'h1;
      if (f_r.tx_on) begin
         f_nxt.tx = {f_r.tx[22:0], 1'b0};
      end

      if (f_r.bit_cnt == 3'h7) begin
         if (f_r.byte_cnt != 2'h3) begin
            f_nxt.byte_cnt = f_r.byte_cnt + 2'h1;
         end
         if (f_r.byte_cnt == 2'h0) begin
            case (rx_byte)
               `SFR_CMD_RESULT: begin
                  f_nxt.tx = l_r.shadow;
                  f_nxt.tx_on = 1'b1;
               end
               `SFR_CMD_NVM_READ: begin
                  f_nxt.nvm_pending = 1'b1;
               end
               `SFR_CMD_IDLE, `SFR_CMD_ACTIVE, `SFR_CMD_TEMP_UPDATE: begin
                  l_nxt.cmd_code = rx_byte;
                  l_nxt.cmd_tog = ~l_r.cmd_tog;
               end
               default: begin
               end
            endcase
         end else if (f_r.nvm_pending) begin
            // three bytes from the given address; refused reads give zeros
            f_nxt.nvm_pending = 1'b0;
            f_nxt.tx_on = 1'b1;
            if (l_r.idle_s2 && l_r.cvalid_s2) begin
               f_nxt.tx = {nvm_byte(rx_byte, c_r.coeff),
                           nvm_byte(rx_byte + 8'h01, c_r.coeff),
                           nvm_byte(rx_byte + 8'h02, c_r.coeff)};
            end else begin
               f_nxt.tx = {3{`SFR_NVM_UNMAPPED}};
            end
         end
      end
   end

   always_ff @(posedge link_sclk or posedge reset) begin
      if (reset) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   always_ff @(posedge link_sclk or posedge frame_rst) begin
      if (frame_rst) begin
         f_r <= '0;
      end else begin
         f_r <= f_nxt;
      end
   end

   // ----------------------------------------------------------------
   // output stage: data changes on the falling edge for mode 0
   // ----------------------------------------------------------------
   always_comb begin
      o_nxt.miso = f_r.tx_on & f_r.tx[23];
      o_nxt.miso_oe = f_r.tx_on;
   end

   always_ff @(negedge link_sclk or posedge frame_rst) begin
      if (frame_rst) begin
         o_r <= '0;
      end else begin
         o_r <= o_nxt;
      end
   end

   assign miso = o_r.miso;
   assign miso_oe = o_r.miso_oe;
   assign conversion_active = c_r.active;

endmodule : sfr_front_end_chip

`default_nettype wire

// ---- hdl/sfr_regs.svh ----
// six-axis force readout: offsets, command codes and timing counts
// assumes inclusion by bare name from the package and the design module
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// non-volatile memory byte addresses of each coefficient msb
`define SFR_COEFF_ONE_ADDR 8'h5a
`define SFR_COEFF_TWO_ADDR 8'h5d
`define SFR_COEFF_THREE_ADDR 8'h60
`define SFR_COEFF_FOUR_ADDR 8'h6c
`define SFR_COEFF_FIVE_ADDR 8'h6f
`define SFR_COEFF_SIX_ADDR 8'h72
`define SFR_NVM_UNMAPPED 8'h00

// command codes of the link
`define SFR_CMD_IDLE 8'h01
`define SFR_CMD_ACTIVE 8'h02
`define SFR_CMD_RESULT 8'h03
`define SFR_CMD_NVM_READ 8'h04
`define SFR_CMD_TEMP_UPDATE 8'h05

// reset values
`define SFR_SAMPLE_RST 24'h000000
`define SFR_TEMP_RST 24'h000000

// timing
`define SFR_CORE_CLK_KHZ 200000
`define SFR_FIRST_CONV_US 7500
`define SFR_CONV_INTERVAL_US 800
`define SFR_COEFF_LOAD_WAIT 2'h3

`endif

// ---- hdl/sfr_pkg.sv ----
// six-axis force readout: types shared by the design
// assumes sfr_regs.svh on the include path
`include "sfr_regs.svh"
`default_nettype none

package sfr_pkg;

   typedef enum logic [1:0] {
      SFR_CONV_IDLE,
      SFR_CONV_FIRST,
      SFR_CONV_RUN
   } sfr_conv_e;

   // core domain state
   typedef struct packed {
      sfr_conv_e state;
      logic active;
      logic [20:0] timer;
      logic [23:0] temp_ref;
      logic [23:0] sample;
      logic pub_tog;
      logic [143:0] coeff;
      logic coeff_valid;
      logic [1:0] ld_cnt;
      logic cmd_s1;
      logic cmd_s2;
      logic cmd_s3;
      logic [23:0] adc_s1;
      logic [23:0] adc_s2;
      logic [23:0] temp_s1;
      logic [23:0] temp_s2;
      logic [143:0] img_s1;
      logic [143:0] img_s2;
   } sfr_core_s;

   // link domain state that survives between frames
   typedef struct packed {
      logic idle_s1;
      logic idle_s2;
      logic cvalid_s1;
      logic cvalid_s2;
      logic pub_s1;
      logic pub_s2;
      logic pub_seen;
      logic [23:0] shadow;
      logic [7:0] cmd_code;
      logic cmd_tog;
   } sfr_link_s;

   // link domain state that ends with the frame
   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [6:0] rx;
      logic [23:0] tx;
      logic tx_on;
      logic nvm_pending;
   } sfr_frame_s;

   // falling-edge output stage
   typedef struct packed {
      logic miso;
      logic miso_oe;
   } sfr_out_s;

endpackage : sfr_pkg

`default_nettype wire

// ---- verification/sfr_front_end_chip_checker.sv ----
// checker of one chip's link replies and conversion flag
// assumes bind to sfr_front_end_chip, link mode 0, 8-bit command first
`include "sfr_regs.svh"
`default_nettype none
module sfr_front_end_chip_checker #(
   parameter int FIRST_CONV_CYCLES = 200,
   parameter int CONV_INTERVAL_CYCLES = 50
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic link_sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic conversion_active
);
   // ---
   // frame tracking
   // ---
   logic [5:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] cmd_r;
   logic [7:0] cmd_now;
   assign cmd_now = (cnt_r == 6'h8) ? sh_r : cmd_r;
   // deselect clears at once, since the link clock stops between frames
   always_ff @(posedge link_sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_r <= 6'h0;
         sh_r <= 8'h0;
         cmd_r <= 8'h0;
      end else begin
         cnt_r <= (cnt_r == 6'h3f) ? cnt_r : cnt_r + 6'h1;
         sh_r <= {sh_r[6:0], mosi};
         if (cnt_r == 6'h8) begin
            cmd_r <= sh_r;
         end
      end
   end
   a_oe_unselected: assert property (@(posedge clk) disable iff (reset) cs_n |-> !miso_oe)
      else $error("reply enable high while deselected");
   a_miso_released: assert property (@(posedge clk) disable iff (reset) !miso_oe |-> !miso)
      else $error("reply data high while not driven");
   a_oe_not_early: assert property (@(posedge link_sclk) disable iff (reset) miso_oe |-> cnt_r >= 6'h8)
      else $error("reply began inside command byte");
   a_result_reply: assert property (@(posedge link_sclk) disable iff (reset)
      cnt_r >= 6'h8 && cmd_now == `SFR_CMD_RESULT |-> miso_oe)
      else $error("no reply to result");
   a_nvm_reply: assert property (@(posedge link_sclk) disable iff (reset)
      cnt_r >= 6'h10 && cmd_now == `SFR_CMD_NVM_READ |-> miso_oe)
      else $error("no reply to memory read");
   a_cmd_silent: assert property (@(posedge link_sclk) disable iff (reset) cnt_r >= 6'h8 &&
      cmd_now != `SFR_CMD_RESULT && (cmd_now != `SFR_CMD_NVM_READ || cnt_r < 6'h10) |-> !miso_oe)
      else $error("reply where none is due");
   a_nvm_refused: assert property (@(posedge link_sclk) disable iff (reset) cnt_r >= 6'h10 &&
      cmd_now == `SFR_CMD_NVM_READ && conversion_active |-> !miso)
      else $error("memory read answered while active");
   a_active_hold: assert property (@(posedge clk) disable iff (reset)
      $rose(conversion_active) |=> conversion_active [*8])
      else $error("conversion flag dropped at once");
   c_result: cover property (@(posedge link_sclk) cnt_r == 6'h8 && cmd_now == `SFR_CMD_RESULT);
   c_nvm: cover property (@(posedge link_sclk) cnt_r == 6'h10 && cmd_now == `SFR_CMD_NVM_READ);
   c_start: cover property (@(posedge clk) $rose(conversion_active));
endmodule : sfr_front_end_chip_checker
`default_nettype wire

// ---- verification/sfr_host_model.sv ----
// host model: link master for six chips, mode 0, msb first
// assumes miso low from every chip that is not replying
`include "sfr_regs.svh"
`default_nettype none
module sfr_host_model (
   output logic link_sclk,
   output logic [5:0] cs_n,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;
   // selects start low, so the bench's rising reset also clears every chip's frame state
   initial begin
      link_sclk = 1'b0;
      cs_n = 6'h00;
      mosi = 1'b0;
      #2 cs_n = 6'h3f;
   end
   // 40 bits carry command, address and reply; clock runs only in frames
   task automatic xfer(input int ch, input logic [7:0] cmd, input logic [7:0] adr, output logic [23:0] rep);
      logic [39:0] o;
      logic [39:0] i;
      o = {cmd, adr, 24'h0};
      #1.3 cs_n[ch] = 1'b0;
      for (int b = 39; b >= 0; b--) begin
         mosi = o[b];
         #3 link_sclk = 1'b1;
         i = {i[38:0], miso};
         #3 link_sclk = 1'b0;
      end
      #3 cs_n[ch] = 1'b1;
      rep = (cmd == `SFR_CMD_NVM_READ) ? i[23:0] : i[31:8];
      mosi = ~mosi;
      #40;
   endtask : xfer
endmodule : sfr_host_model
`default_nettype wire

// ---- verification/six_axis_force_readout_sequencer_bench.sv ----
// self-checking bench: six chips on one link, host model as master
// assumes design and host model compiled first; chip c holds matrix row c
`include "sfr_regs.svh"
`default_nettype none
module six_axis_force_readout_sequencer_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic reset = 1'b0;
   logic [23:0] adc [6];
   logic [23:0] temp [6];
   logic [23:0] tref [6];
   logic [143:0] img [6];
   logic [23:0] cf [6][6];
   logic [23:0] smp [6];
   logic [5:0] cs_n, miso_w, oe_w, act;
   logic link_sclk, mosi;
   logic [23:0] r, e;
   int mismatches = 0;
   int comparisons = 0;
   logic [7:0] addr [6] = '{8'h5a, 8'h5d, 8'h60, 8'h6c, 8'h6f, 8'h72};
   always #2.5 clk = ~clk;
   for (genvar g = 0; g < 6; g++) begin : chip
      sfr_front_end_chip #(.FIRST_CONV_CYCLES(200), .CONV_INTERVAL_CYCLES(50)) dut_u (.clk(clk), .reset(reset),
         .link_sclk(link_sclk), .cs_n(cs_n[g]), .mosi(mosi), .miso(miso_w[g]), .miso_oe(oe_w[g]),
         .adc_code(adc[g]), .temp_code(temp[g]), .nvm_image(img[g]), .conversion_active(act[g]));
   end
   sfr_host_model host_u (.link_sclk(link_sclk), .cs_n(cs_n), .mosi(mosi), .miso(|miso_w));
   task automatic print_verdict();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // the sample reaches the shadow three link clock edges after its toggle, so only the second reply counts
   task automatic rd(input int ch, input logic [23:0] exp);
      host_u.xfer(ch, `SFR_CMD_RESULT, 8'h00, r);
      host_u.xfer(ch, `SFR_CMD_RESULT, 8'h00, r);
      smp[ch] = r;
      chk(r, exp);
   endtask : rd
   task automatic all(input logic [7:0] cmd);
      for (int i = 0; i < 6; i++) host_u.xfer(i, cmd, 8'h00, r);
   endtask : all
   // host matrix step on read-back words against the same step on model words
   task automatic matrix();
      longint axis_acc;
      longint model_acc;
      for (int a = 0; a < 6; a++) begin
         axis_acc = 0;
         model_acc = 0;
         for (int k = 0; k < 6; k++) begin
            axis_acc += longint'($signed(cf[a][k])) * longint'($signed(smp[k]));
            model_acc += longint'($signed(img[a][k*24+:24])) * longint'($signed(24'(adc[k] - temp[k])));
         end
         chk(axis_acc >>> 11, model_acc >>> 11);
      end
   endtask : matrix
   initial begin
      void'($urandom(32'hf6a8));
      for (int i = 0; i < 6; i++) begin
         adc[i] = 24'($urandom);
         temp[i] = 24'($urandom);
         for (int j = 0; j < 6; j++) img[i][j*24+:24] = 24'($urandom);
      end
      // a real rising edge, since the link clock is still at rest
      #1 reset = 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      repeat (20) @(negedge clk);
      for (int c = 0; c < 6; c++) rd(c, 24'h0);
      all(`SFR_CMD_IDLE);
      for (int c = 0; c < 6; c++) begin
         for (int k = 0; k < 6; k++) begin
            host_u.xfer(c, `SFR_CMD_NVM_READ, addr[k], r);
            cf[c][k] = r;
            chk(r, img[c][k*24+:24]);
         end
      end
      host_u.xfer(1, `SFR_CMD_NVM_READ, 8'h61, r);
      chk(r, {img[1][63:48], 8'h00});
      all(`SFR_CMD_ACTIVE);
      rd(5, 24'h0);
      chk({18'h0, act}, 24'h3f);
      host_u.xfer(0, `SFR_CMD_NVM_READ, 8'h5a, r);
      chk(r, 24'h0);
      repeat (300) @(negedge clk);
      for (int c = 0; c < 6; c++) rd(c, adc[c] - temp[c]);
      @(negedge clk);
      for (int c = 0; c < 6; c++) begin
         tref[c] = temp[c];
         adc[c] = 24'($urandom);
         temp[c] = 24'($urandom);
      end
      repeat (60) @(negedge clk);
      for (int c = 0; c < 6; c++) rd(c, adc[c] - tref[c]);
      all(`SFR_CMD_TEMP_UPDATE);
      repeat (60) @(negedge clk);
      for (int c = 0; c < 6; c++) rd(c, adc[c] - temp[c]);
      repeat (100) @(negedge clk);
      matrix();
      all(`SFR_CMD_IDLE);
      @(negedge clk);
      e = adc[0] - temp[0];
      adc[0] = ~adc[0];
      repeat (60) @(negedge clk);
      chk({18'h0, act}, 24'h0);
      rd(0, e);
      host_u.xfer(0, `SFR_CMD_ACTIVE, 8'h00, r);
      rd(0, 24'h0);
      print_verdict();
   end
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
endmodule : six_axis_force_readout_sequencer_bench
bind sfr_front_end_chip sfr_front_end_chip_checker #(.FIRST_CONV_CYCLES(FIRST_CONV_CYCLES),
   .CONV_INTERVAL_CYCLES(CONV_INTERVAL_CYCLES)) chk_u (.clk(clk), .reset(reset), .link_sclk(link_sclk),
   .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .conversion_active(conversion_active));
`default_nettype wire
